// ---- include/pmux_pkg.sv ----
// ----------------------------------------------------------------
// pin mux constants and carriers
// ----------------------------------------------------------------
package pmux_pkg;

   // widths of the pad groups handled here
   localparam int PMUX_A_W = 4;   // port a bits 4..7
   localparam int PMUX_B_W = 8;   // port b bits 0..7
   localparam int PMUX_D_W = 5;   // port d bits 0..4
   localparam int PMUX_PAD_W = PMUX_A_W + PMUX_B_W + PMUX_D_W;
   localparam int PMUX_BUS_W = 16;

   // interface_config[1:0] encodings
   localparam logic [1:0] PMUX_IFC_PORTS = 2'h0;
   localparam logic [1:0] PMUX_IFC_PROG = 2'h2;
   localparam logic [1:0] PMUX_IFC_FIFO = 2'h3;

   // field positions
   localparam int PMUX_ALT_CFG_A7 = 7;    // port_a_alt_config bit
   localparam int PMUX_POL_COMMIT = 5;    // fifo_pin_polarity bit
   localparam int PMUX_EPCFG_WIDE = 0;    // endpoint_fifo_config bit

   // positions inside the port a group
   localparam int PMUX_A_SEL0 = 0;   // port_a_bit4
   localparam int PMUX_A_SEL1 = 1;   // port_a_bit5
   localparam int PMUX_A_COMMIT = 2; // port_a_bit6
   localparam int PMUX_A_BIT7 = 3;   // port_a_bit7

   // reset values
   localparam logic [1:0] PMUX_IFC_RST = PMUX_IFC_PORTS;
   localparam logic [7:0] PMUX_CFG8_RST = 8'h00;
   localparam logic [2:0] PMUX_STB_W0 = 3'h0;

   // decoded interface mode
   typedef enum logic [1:0] {
      PMUX_MODE_PORTS,
      PMUX_MODE_PROG,
      PMUX_MODE_FIFO
   } pmux_mode_e;

   // role of the port a bit 7 pad
   typedef enum logic [1:0] {
      PMUX_A7_PORT,
      PMUX_A7_FLAG,
      PMUX_A7_CS
   } pmux_a7_e;

   // one bit per pad of the group
   typedef struct packed {
      logic [PMUX_D_W-1:0] d;
      logic [PMUX_B_W-1:0] b;
      logic [PMUX_A_W-1:0] a;
   } pmux_pads_s;

   // software configuration bundle
   typedef struct packed {
      logic [1:0] interface_config;
      logic [7:0] port_a_alt_config;
      logic [7:0] fifo_pin_polarity;
      logic [7:0] endpoint_fifo_config;
   } pmux_cfg_s;

endpackage

// ---- rtl/pmux_sync.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// two-stage synchroniser for the pad inputs
// ----------------------------------------------------------------
module pmux_sync
   import pmux_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire pmux_pads_s async_in,
   output pmux_pads_s sync_out
);

   pmux_pads_s meta_r;   // first stage, read only by second stage
   pmux_pads_s sync_r;   // second stage

   // first and second stage, cleared on reset
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
      end
   end

   assign sync_out = sync_r;

endmodule

// ---- rtl/pmux_pin_mux.sv ----
`timescale 1ns/10ps
module pmux_pin_mux
   import pmux_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_in,
   // software configuration
   input wire pmux_cfg_s cfg_in,
   // software gpio side
   input wire pmux_pads_s gpio_data_in,
   input wire pmux_pads_s gpio_dir_in,
   output pmux_pads_s gpio_read_out,
   // fifo core side
   input wire logic [PMUX_BUS_W-1:0] fifo_data_bus_in,
   input wire logic fifo_data_drive_in,
   input wire logic fifo_flag_fourth_in,
   input wire logic [2:0] strobe_req_in,
   output logic [PMUX_BUS_W-1:0] fifo_data_bus_out,
   output logic [1:0] fifo_select_out,
   output logic packet_commit_out,
   output logic [2:0] strobe_gated_out,
   output logic chip_select_active_out,
   // pads
   input wire pmux_pads_s pad_in,
   output pmux_pads_s pad_out,
   output pmux_pads_s pad_oe_out
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------

   // interface field to mode; the unused code behaves as ports
   function automatic pmux_mode_e mode_of(input logic [1:0] ifc);
      unique case (ifc)
         PMUX_IFC_PROG: mode_of = PMUX_MODE_PROG;
         PMUX_IFC_FIFO: mode_of = PMUX_MODE_FIFO;
         default: mode_of = PMUX_MODE_PORTS;
      endcase
   endfunction

   // pick a bus value where the bus owns the pad, else gpio value
   function automatic logic [PMUX_B_W-1:0] pick8(
      input logic sel,
      input logic [PMUX_B_W-1:0] bus_v,
      input logic [PMUX_B_W-1:0] gpio_v);
      pick8 = sel ? bus_v : gpio_v;
   endfunction

   // ----------------------------------------------------------------
   // pad input synchroniser
   // ----------------------------------------------------------------
   pmux_pads_s pad_sync;   // pads after two flops

   pmux_sync u_sync (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .async_in(pad_in),
      .sync_out(pad_sync)
   );

   // ----------------------------------------------------------------
   // configuration capture
   // ----------------------------------------------------------------
   pmux_cfg_s cfg_r;   // configuration in force
   pmux_cfg_s cfg_nxt;
   pmux_mode_e mode;   // decoded interface mode
   pmux_a7_e a7_role;  // role of port a bit 7
   logic bus_mode;     // data bus owns port b
   logic wide_mode;    // data bus also owns port d
   logic commit_pol;   // 1: packet commit active high

   // taken one cycle late so all pads switch together
   always_comb begin
      cfg_nxt = cfg_in;
   end

   // reset puts the block back to plain ports
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cfg_r.interface_config <= PMUX_IFC_RST;
         cfg_r.port_a_alt_config <= PMUX_CFG8_RST;
         cfg_r.fifo_pin_polarity <= PMUX_CFG8_RST;
         cfg_r.endpoint_fifo_config <= PMUX_CFG8_RST;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // mode decode from the captured settings
   always_comb begin
      mode = mode_of(cfg_r.interface_config);
      bus_mode = (mode != PMUX_MODE_PORTS);
      wide_mode = bus_mode &&
         cfg_r.endpoint_fifo_config[PMUX_EPCFG_WIDE];
      commit_pol = cfg_r.fifo_pin_polarity[PMUX_POL_COMMIT];
      // flag role wins over chip select when both could apply
      if (cfg_r.port_a_alt_config[PMUX_ALT_CFG_A7]) begin
         a7_role = PMUX_A7_FLAG;
      end else if (mode == PMUX_MODE_FIFO) begin
         a7_role = PMUX_A7_CS;
      end else begin
         a7_role = PMUX_A7_PORT;
      end
   end

   // ----------------------------------------------------------------
   // fifo control inputs
   // ----------------------------------------------------------------
   logic cs_ok;          // chip select lets strobes through
   logic commit_level;   // packet commit asserted, polarity applied
   logic commit_prev_r;  // last cycle's commit level
   logic commit_prev_nxt;
   logic packet_commit_r;
   logic packet_commit_nxt;
   logic [1:0] fifo_select_r;
   logic [1:0] fifo_select_nxt;
   logic [2:0] strobe_gated_r;
   logic [2:0] strobe_gated_nxt;
   logic cs_active_r;
   logic cs_active_nxt;

   // strobe gating, select capture and commit edge detect
   always_comb begin
      // without the chip select role strobes are always allowed
      cs_ok = (a7_role != PMUX_A7_CS) ||
         !pad_sync.a[PMUX_A_BIT7];
      commit_level = (mode == PMUX_MODE_FIFO) &&
         (pad_sync.a[PMUX_A_COMMIT] == commit_pol);
      commit_prev_nxt = commit_level;
      // one pulse per assertion; a held level commits only once
      packet_commit_nxt = commit_level && !commit_prev_r &&
         cs_ok;
      strobe_gated_nxt = cs_ok ? strobe_req_in : PMUX_STB_W0;
      cs_active_nxt = (a7_role == PMUX_A7_CS) && cs_ok;
      if (mode == PMUX_MODE_FIFO) begin
         fifo_select_nxt = {pad_sync.a[PMUX_A_SEL1],
            pad_sync.a[PMUX_A_SEL0]};
      end else begin
         fifo_select_nxt = 2'h0;
      end
   end

   // control output registers
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         commit_prev_r <= 1'b0;
         packet_commit_r <= 1'b0;
         fifo_select_r <= 2'h0;
         strobe_gated_r <= PMUX_STB_W0;
         cs_active_r <= 1'b0;
      end else begin
         commit_prev_r <= commit_prev_nxt;
         packet_commit_r <= packet_commit_nxt;
         fifo_select_r <= fifo_select_nxt;
         strobe_gated_r <= strobe_gated_nxt;
         cs_active_r <= cs_active_nxt;
      end
   end

   // ----------------------------------------------------------------
   // pad drivers and read-back
   // ----------------------------------------------------------------
   pmux_pads_s pad_out_r;
   pmux_pads_s pad_out_nxt;
   pmux_pads_s pad_oe_r;
   pmux_pads_s pad_oe_nxt;
   pmux_pads_s gpio_read_r;
   pmux_pads_s gpio_read_nxt;
   logic [PMUX_BUS_W-1:0] bus_read_r;
   logic [PMUX_BUS_W-1:0] bus_read_nxt;

   // per-pad value and enable by role
   always_comb begin
      // port role: software owns value and direction
      pad_out_nxt = gpio_data_in;
      pad_oe_nxt = gpio_dir_in;
      // fifo role: select and commit pads are input only
      if (mode == PMUX_MODE_FIFO) begin
         pad_out_nxt.a[2:0] = 3'h0;
         pad_oe_nxt.a[2:0] = 3'h0;
      end
      unique case (a7_role)
         PMUX_A7_FLAG: begin
            pad_out_nxt.a[PMUX_A_BIT7] = fifo_flag_fourth_in;
            pad_oe_nxt.a[PMUX_A_BIT7] = 1'b1;
         end
         PMUX_A7_CS: begin
            pad_out_nxt.a[PMUX_A_BIT7] = 1'b0;
            pad_oe_nxt.a[PMUX_A_BIT7] = 1'b0;
         end
         PMUX_A7_PORT: begin
         end
      endcase
      // low byte of the data bus
      pad_out_nxt.b = pick8(bus_mode, fifo_data_bus_in[7:0],
         gpio_data_in.b);
      pad_oe_nxt.b = pick8(bus_mode, {PMUX_B_W{fifo_data_drive_in}},
         gpio_dir_in.b);
      // high byte, only the pads of this group
      if (wide_mode) begin
         pad_out_nxt.d = fifo_data_bus_in[8 +: PMUX_D_W];
         pad_oe_nxt.d = {PMUX_D_W{fifo_data_drive_in}};
      end
      // software always sees the pad level
      gpio_read_nxt = pad_sync;
      bus_read_nxt = '0;
      if (bus_mode) begin
         bus_read_nxt[7:0] = pad_sync.b;
      end
      if (wide_mode) begin
         bus_read_nxt[8 +: PMUX_D_W] = pad_sync.d;
      end
   end

   // pads released to input on reset
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         pad_out_r <= '0;
         pad_oe_r <= '0;
         gpio_read_r <= '0;
         bus_read_r <= '0;
      end else begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r <= pad_oe_nxt;
         gpio_read_r <= gpio_read_nxt;
         bus_read_r <= bus_read_nxt;
      end
   end

   assign pad_out = pad_out_r;
   assign pad_oe_out = pad_oe_r;
   assign gpio_read_out = gpio_read_r;
   assign fifo_data_bus_out = bus_read_r;
   assign fifo_select_out = fifo_select_r;
   assign packet_commit_out = packet_commit_r;
   assign strobe_gated_out = strobe_gated_r;
   assign chip_select_active_out = cs_active_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_sel_input_only: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      (mode == PMUX_MODE_FIFO) |=> (pad_oe_out.a[2:0] == 3'h0))
      else $error("select or commit pad driven in fifo mode");

   a_sel_follows_pad: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      (mode == PMUX_MODE_FIFO) |=>
      (fifo_select_out == $past(pad_sync.a[1:0])))
      else $error("fifo select does not follow pads");

   a_commit_one_pulse: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      packet_commit_out |=> !packet_commit_out)
      else $error("packet commit longer than one cycle");

   a_cs_blocks_strobe: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      (a7_role == PMUX_A7_CS && pad_sync.a[PMUX_A_BIT7]) |=>
      (strobe_gated_out == 3'h0 && !packet_commit_out))
      else $error("strobe passed without chip select");

   a_flag_drive: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      (a7_role == PMUX_A7_FLAG) |=> (pad_oe_out.a[PMUX_A_BIT7] &&
      pad_out.a[PMUX_A_BIT7] == $past(fifo_flag_fourth_in)))
      else $error("flag pad not driving the flag");

   a_low_byte_bus: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      bus_mode |=> (pad_out.b == $past(fifo_data_bus_in[7:0])))
      else $error("low byte not on port b");

   a_high_byte_port: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      !wide_mode |=> (pad_oe_out.d == $past(gpio_dir_in.d)))
      else $error("port d taken without word-wide");

   a_gpio_readback: assert property (
      @(posedge core_clk_in) disable iff (reset_in)
      (mode == PMUX_MODE_PORTS) |=> (gpio_read_out.b ==
      $past(pad_sync.b) && pad_oe_out.b == $past(gpio_dir_in.b)))
      else $error("gpio line not under software control");

   a_reset_inputs: assert property (
      @(posedge core_clk_in)
      reset_in |=> (pad_oe_out == '0))
      else $error("pad driven right after reset");

endmodule

// ---- verif/pmux_master.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// external bus master as seen from the pads
// ----------------------------------------------------------------
module pmux_master
   import pmux_pkg::*;
(
   input wire logic core_clk_in,
   input wire pmux_pads_s pad_out_in,
   input wire pmux_pads_s pad_oe_in,
   input wire pmux_pads_s drv_val_in,
   input wire pmux_pads_s drv_en_in,
   output pmux_pads_s wire_out
);
   pmux_pads_s last_r = '0; // last resolved wire level
   logic [PMUX_PAD_W-1:0] dev_v; // device share of the wire
   logic [PMUX_PAD_W-1:0] mst_v; // master share of the wire
   // remember the wire so released lines can show its inverse
   always @(posedge core_clk_in) begin
      last_r <= wire_out;
   end
   // released lines flip each cycle, so a stale value cannot pass
   assign dev_v = pad_oe_in & pad_out_in;
   // master drives each line it enables that the device releases: selects, commit, chip select and data
   assign mst_v = ~pad_oe_in & drv_en_in & drv_val_in;
   // wire: device wins where it drives, else master, else the inverse of its last level
   assign wire_out = dev_v | mst_v | (~pad_oe_in & ~drv_en_in & ~last_r);
endmodule

// ---- verif/tb_pmux_pin_mux.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bench for the pin multiplexer
// ----------------------------------------------------------------
module tb_pmux_pin_mux;
   import pmux_pkg::*;
   localparam logic [16:0] GD = 17'h0a5c3; // gpio drive pattern
   logic core_clk_in = 1'b0; // bench clock
   logic reset_in = 1'b1; // bench reset
   pmux_cfg_s cfg = '0; // software configuration
   // direction starts as software leaves it after reset: all inputs
   pmux_pads_s gdat = GD, gdir = '0; // gpio value, direction
   pmux_pads_s grd, pin, pout, poe; // read-back and pad wires
   pmux_pads_s mval = '0, men = '0; // master drive value and enable
   logic [15:0] fdi = '0, fdo; // core side data bus
   logic fdrv = 1'b0, flag = 1'b0, pc, csa; // drive, flag, commit, cs
   logic [1:0] fsel; // fifo select seen
   logic [2:0] sreq = '0, sg; // strobe request and gated strobe
   int mismatches = 0, compares = 0, commits = 0, c0;
   // ----------------------------------------------------------------
   // clock, design and far side
   // ----------------------------------------------------------------
   always #10 core_clk_in = ~core_clk_in;
   pmux_pin_mux DUT (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .cfg_in(cfg), .gpio_data_in(gdat), .gpio_dir_in(gdir),
      .gpio_read_out(grd), .fifo_data_bus_in(fdi),
      .fifo_data_drive_in(fdrv), .fifo_flag_fourth_in(flag),
      .strobe_req_in(sreq), .fifo_data_bus_out(fdo),
      .fifo_select_out(fsel), .packet_commit_out(pc),
      .strobe_gated_out(sg), .chip_select_active_out(csa),
      .pad_in(pin), .pad_out(pout), .pad_oe_out(poe));
   pmux_master master (.core_clk_in(core_clk_in), .pad_out_in(pout),
      .pad_oe_in(poe), .drv_val_in(mval), .drv_en_in(men),
      .wire_out(pin));
   // count one-cycle commit pulses
   always @(posedge core_clk_in) begin
      if (pc === 1'b1) begin
         commits <= commits + 1;
      end
   end
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // longest checked path is five edges (config to fifo select through the released pads); five leaves no margin
   task automatic settle;
      repeat (5) @(posedge core_clk_in);
      #1;
   endtask
   task automatic set_cfg(input logic [1:0] ifc, input logic [7:0] alt,
         input logic [7:0] pol, input logic [7:0] ep);
      @(posedge core_clk_in);
      cfg <= {ifc, alt, pol, ep};
      settle();
   endtask
   task automatic set_pads(input pmux_pads_s v, input pmux_pads_s e);
      @(posedge core_clk_in);
      mval <= v;
      men <= e;
      settle();
   endtask
   task automatic set_core(input logic [15:0] d, input logic drv,
         input logic fl, input logic [2:0] s);
      @(posedge core_clk_in);
      fdi <= d;
      fdrv <= drv;
      flag <= fl;
      sreq <= s;
      settle();
   endtask
   task automatic set_gpio(input pmux_pads_s d, input pmux_pads_s r);
      @(posedge core_clk_in);
      gdat <= d;
      gdir <= r;
      settle();
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge core_clk_in);
      #1;
      check(poe, 17'h0);
      @(posedge core_clk_in);
      reset_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      check(poe, 17'h0);
      $display("test reset done");
      // ports mode: gpio drive then gpio read
      set_gpio(GD, 17'h1ffff);
      check(pout, GD);
      check(poe, 17'h1ffff);
      set_gpio(GD, 17'h0);
      set_pads(17'h1b3a6, 17'h1ffff);
      check(grd, 17'h1b3a6);
      set_pads({5'h0, 8'h0, 4'h2}, {5'h0, 8'h0, 4'hf});
      set_gpio(GD, 17'h1ffff);
      $display("test ports done");
      // fifo mode, byte wide, chip select low
      set_cfg(PMUX_IFC_FIFO, 8'h00, 8'h20, 8'h00);
      check(fsel, 2'h2);
      check(poe.a, 4'h0);
      set_core(16'h1a5c, 1'b1, 1'b0, 3'h5);
      check(pout.b, 8'h5c);
      check(poe.b, 8'hff);
      check(pout.d, 5'h0a);
      check(csa, 1'b1);
      check(sg, 3'h5);
      c0 = commits;
      set_pads({5'h0, 8'h0, 4'h6}, {5'h0, 8'h0, 4'hf});
      check(17'(commits - c0), 17'h1);
      // chip select high blocks strobes and commit
      set_pads({5'h0, 8'h0, 4'ha}, {5'h0, 8'h0, 4'hf});
      check(sg, 3'h0);
      check(csa, 1'b0);
      c0 = commits;
      set_pads({5'h0, 8'h0, 4'he}, {5'h0, 8'h0, 4'hf});
      check(17'(commits - c0), 17'h0);
      // active low commit polarity
      set_cfg(PMUX_IFC_FIFO, 8'h00, 8'h00, 8'h00);
      set_pads({5'h0, 8'h0, 4'h6}, {5'h0, 8'h0, 4'hf});
      c0 = commits;
      set_pads({5'h0, 8'h0, 4'h2}, {5'h0, 8'h0, 4'hf});
      check(17'(commits - c0), 17'h1);
      $display("test fifo byte done");
      // word wide: port d joins the bus both ways
      set_cfg(PMUX_IFC_FIFO, 8'h00, 8'h00, 8'h01);
      check(pout.d, 5'h1a);
      check(poe.d, 5'h1f);
      set_core(16'h0, 1'b0, 1'b0, 3'h0);
      set_pads({5'h15, 8'h3c, 4'h2}, {5'h1f, 8'hff, 4'hf});
      check(fdo, 16'h153c);
      $display("test fifo word done");
      // port a bit 7 as flag output, then back to gpio
      set_pads({5'h0, 8'h0, 4'h2}, {5'h0, 8'h0, 4'h7});
      set_cfg(PMUX_IFC_FIFO, 8'h80, 8'h00, 8'h01);
      set_core(16'h0, 1'b0, 1'b1, 3'h0);
      check(poe.a[3], 1'b1);
      check(pout.a[3], 1'b1);
      set_pads('0, '0);
      set_cfg(PMUX_IFC_PORTS, 8'h00, 8'h00, 8'h00);
      check(poe, 17'h1ffff);
      $display("test bit7 done");
      // programmable mode: low byte on bus, port d stays gpio
      set_cfg(PMUX_IFC_PROG, 8'h00, 8'h00, 8'h00);
      set_core(16'h00a5, 1'b1, 1'b0, 3'h0);
      check(pout.b, 8'ha5);
      check(pout.d, 5'h0a);
      // reset in mid-run returns every pad to input
      @(posedge core_clk_in);
      reset_in <= 1'b1;
      settle();
      check(poe, 17'h0);
      $display("test prog and reset done");
      summarize();
   end
endmodule
